// *** acsi_pkg.sv ***
// Shared constants and types of the serial command interface
package acsi_pkg;
	// Result code format
	localparam int RESULT_W = 16;
	localparam logic [15:0] CODE_MAX = 16'h7fff;
	localparam logic [15:0] CODE_MIN = 16'h8000;
	// Polling trailer: eight low bits then eight high bits after a result
	localparam logic [15:0] RESULT_TRAILER = 16'h00ff;
	// Idle fill behind a register byte
	localparam logic [23:0] REG_FILL = 24'hffffff;

	// Command patterns, bit 0 ignored for the first three
	localparam logic [6:0] CMD_RESET_PAT = 7'h03;
	localparam logic [6:0] CMD_START_PAT = 7'h04;
	localparam logic [6:0] CMD_SLEEP_PAT = 7'h02 >> 1;
	localparam logic [3:0] CMD_RDATA_NIB = 4'h1;
	localparam logic [3:0] CMD_REGISTER_READ_CMD_NIB = 4'h2;
	localparam logic [3:0] CMD_REGISTER_WRITE_CMD_NIB = 4'h4;

	// Register offsets
	localparam logic [1:0] REG_INPUT_SELECT_GAIN = 2'h0;
	localparam logic [1:0] REG_RATE_MODE_CONVERSION = 2'h1;
	localparam logic [1:0] REG_REFERENCE_FILTER_CURRENT = 2'h2;
	localparam logic [1:0] REG_CURRENT_ROUTING_READY_CFG = 2'h3;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] ROUTING_WRITE_MASK = 8'hfe;

	// Field positions
	localparam int MODE_LSB = 3;
	localparam logic [1:0] MODE_TURBO = 2'h2;
	localparam int CONV_MODE_BIT = 2;
	localparam int LOW_SIDE_SW_BIT = 3;
	localparam int EXC_LSB = 0;
	localparam int READY_SEL_BIT = 1;

	// Timing
	localparam longint SYS_CLK_HZ = 10000000;
	localparam longint RESET_WAIT_NS = 50000;
	localparam longint RESET_WAIT_CLKS = 32;
	localparam longint RESET_WAIT_CYC =
		(RESET_WAIT_NS * SYS_CLK_HZ + 64'd999999999) / 64'd1000000000 + RESET_WAIT_CLKS;
	localparam int HOLD_W = 10;
	localparam logic [HOLD_W-1:0] RESET_HOLD_CYC = HOLD_W'(RESET_WAIT_CYC);
	localparam int TIMEOUT_MOD_NORMAL = 14000;
	localparam int TIMEOUT_MOD_TURBO = 28000;
	localparam int MOD_DIV_NORMAL = 16;
	localparam int MOD_DIV_TURBO = 8;
	localparam int TIMEOUT_CYC_NORMAL = TIMEOUT_MOD_NORMAL * MOD_DIV_NORMAL;
	localparam int TIMEOUT_CYC_TURBO = TIMEOUT_MOD_TURBO * MOD_DIV_TURBO;

	typedef logic [3:0][7:0] acsi_cfg_t;
	typedef enum logic [1:0] {ST_CMD, ST_RDATA, ST_REGISTER_READ_CMD, ST_REGISTER_WRITE_CMD} acsi_state_t;
	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic din;
	} acsi_pins_t;
endpackage : acsi_pkg

// *** acsi_sync.sv ***
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module acsi_sync #(
	parameter int WIDTH = 3
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} acsi_sync_t;
	acsi_sync_t s_reg;
	acsi_sync_t s_next;

	// The meta stage feeds only the stable stage
	always_comb
	begin
		s_next = s_reg;
		s_next.meta = async_in;
		s_next.stable = s_reg.meta;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			s_reg <= '1;
		else
			s_reg <= s_next;
	end

	assign sync_out = s_reg.stable;
endmodule : acsi_sync

// *** acsi_fifo.sv ***
// Result FIFO with registered read data and back-pressure
`timescale 1ns/1ps
module acsi_fifo #(
	parameter int WIDTH = 20,
	parameter int DEPTH = 16
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int PW = $clog2(DEPTH);
	generate
		if (DEPTH < 2 || (1 << PW) != DEPTH)
			$error("acsi_fifo: DEPTH must be a power of two, at least 2");
	endgenerate
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [PW:0] cnt;
		logic ready;
		logic ov;
		logic [WIDTH-1:0] od;
	} acsi_fifo_t;
	acsi_fifo_t s_reg;
	acsi_fifo_t s_next;
	logic push;
	logic load;

	// Output word is refilled from storage whenever it is empty or taken
	always_comb
	begin
		s_next = s_reg;
		push = in_valid && s_reg.ready;
		load = (s_reg.cnt != '0) && (!s_reg.ov || out_ready);
		if (push)
		begin
			s_next.mem[s_reg.wp] = in_data;
			s_next.wp = s_reg.wp + 1'b1;
		end
		if (load)
		begin
			s_next.od = s_reg.mem[s_reg.rp];
			s_next.rp = s_reg.rp + 1'b1;
			s_next.ov = 1'b1;
		end
		else if (s_reg.ov && out_ready)
			s_next.ov = 1'b0;
		s_next.cnt = s_reg.cnt + (PW+1)'(push) - (PW+1)'(load);
		// The output word counts toward the depth, so DEPTH words fill it exactly
		s_next.ready = ((s_next.cnt + (PW+1)'(s_next.ov)) != (PW+1)'(DEPTH));
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			s_reg <= '0;
			s_reg.ready <= 1'b1;
		end
		else
			s_reg <= s_next;
	end

	assign in_ready = s_reg.ready;
	assign out_valid = s_reg.ov;
	assign out_data = s_reg.od;
endmodule : acsi_fifo

// *** acsi_top.sv ***
// Serial command interpreter and result readout of the converter
`timescale 1ns/1ps
module acsi_top #(
	parameter int RAW_W = 20,
	parameter int FIFO_DEPTH = 16,
	parameter int TIMEOUT_NORMAL_CYC = acsi_pkg::TIMEOUT_CYC_NORMAL,
	parameter int TIMEOUT_TURBO_CYC = acsi_pkg::TIMEOUT_CYC_TURBO
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire acsi_pkg::acsi_pins_t pins,
	output logic serial_out_with_ready,
	output logic serial_out_with_ready_oe_n,
	output logic result_ready_n,
	input wire logic raw_valid,
	input wire logic [RAW_W-1:0] raw_data,
	output logic raw_ready,
	input wire logic conv_busy,
	output logic conv_start,
	output logic filter_clear,
	output logic device_reset,
	output logic conversion_mode_sel,
	output logic analog_on,
	output logic low_side_switch_ctl,
	output logic [2:0] excitation_current_src,
	output acsi_pkg::acsi_cfg_t cfg_out
);
	localparam int TO_MAX = (TIMEOUT_TURBO_CYC > TIMEOUT_NORMAL_CYC) ?
		TIMEOUT_TURBO_CYC : TIMEOUT_NORMAL_CYC;
	localparam int TO_W = $clog2(TO_MAX + 1);
	generate
		if (RAW_W < acsi_pkg::RESULT_W)
			$error("acsi_top: RAW_W must be at least the result width");
		if (TIMEOUT_NORMAL_CYC < 2 || TIMEOUT_TURBO_CYC < 2)
			$error("acsi_top: timeouts must be at least two cycles");
	endgenerate

	typedef struct packed {
		acsi_pkg::acsi_state_t st;
		logic cs_d;
		logic sclk_d;
		logic [2:0] bit_cnt;
		logic [7:0] shin;
		logic [31:0] out_sr;
		logic [5:0] out_cnt;
		logic [1:0] ptr;
		logic [1:0] remain;
		logic [15:0] buffer;
		logic unread;
		acsi_pkg::acsi_cfg_t cfg;
		acsi_pkg::acsi_cfg_t stage;
		logic dout;
		logic oe_n;
		logic rdy_n;
		logic conv_start;
		logic filter_clear;
		logic dev_reset;
		logic pd_pending;
		logic sleeping;
		logic analog_on;
		logic lsw;
		logic [2:0] exc;
		logic [acsi_pkg::HOLD_W-1:0] hold_cnt;
		logic [TO_W-1:0] to_cnt;
	} acsi_top_t;
	acsi_top_t s_reg;
	acsi_top_t s_next;

	acsi_pkg::acsi_pins_t pins_s;
	logic fifo_valid;
	logic [RAW_W-1:0] fifo_data;
	logic pop_ok;
	logic pop_fire;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic byte_done;
	logic [7:0] rx_byte;
	logic turbo;
	logic [TO_W-1:0] to_limit;

	acsi_sync #(
		.WIDTH(3)
	) u_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.async_in(pins),
		.sync_out(pins_s)
	);

	acsi_fifo #(
		.WIDTH(RAW_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.rst(rst),
		.in_valid(raw_valid),
		.in_data(raw_data),
		.in_ready(raw_ready),
		.out_valid(fifo_valid),
		.out_data(fifo_data),
		.out_ready(pop_ok)
	);

	// Clipping of the raw result to the code range
	function automatic logic [15:0] sat_code(input logic [RAW_W-1:0] raw);
		logic signed [RAW_W-1:0] v;
		logic signed [RAW_W-1:0] hi;
		logic signed [RAW_W-1:0] lo;
		v = raw;
		hi = RAW_W'($signed(acsi_pkg::CODE_MAX));
		lo = RAW_W'($signed(acsi_pkg::CODE_MIN));
		if (v > hi)
			sat_code = acsi_pkg::CODE_MAX;
		else if (v < lo)
			sat_code = acsi_pkg::CODE_MIN;
		else
			sat_code = v[15:0];
	endfunction : sat_code

	// Edge detection on synchronised pins; clock ignored while deselected
	assign sclk_rise = pins_s.sclk && !s_reg.sclk_d && !pins_s.cs_n;
	assign sclk_fall = !pins_s.sclk && s_reg.sclk_d && !pins_s.cs_n;
	assign cs_fall = !pins_s.cs_n && s_reg.cs_d;
	assign byte_done = sclk_fall && (s_reg.bit_cnt == 3'h7);
	assign rx_byte = {s_reg.shin[6:0], pins_s.din};
	assign turbo = s_reg.cfg[acsi_pkg::REG_RATE_MODE_CONVERSION][acsi_pkg::MODE_LSB +: 2]
		== acsi_pkg::MODE_TURBO;
	assign to_limit = turbo ? TO_W'(TIMEOUT_TURBO_CYC - 1) : TO_W'(TIMEOUT_NORMAL_CYC - 1);
	// A result stalls in the FIFO while a direct read is half way out
	assign pop_ok = !(s_reg.st == acsi_pkg::ST_CMD && s_reg.out_cnt != 6'h00
		&& s_reg.out_cnt < 6'h10) && (s_reg.hold_cnt == '0);
	assign pop_fire = fifo_valid && pop_ok;

	// Next state of the whole interpreter
	always_comb
	begin
		s_next = s_reg;
		s_next.cs_d = pins_s.cs_n;
		s_next.sclk_d = pins_s.sclk;
		s_next.conv_start = 1'b0;
		s_next.filter_clear = 1'b0;
		s_next.dev_reset = 1'b0;
		if (s_reg.hold_cnt != '0)
			s_next.hold_cnt = s_reg.hold_cnt - 1'b1;
		// New result into the data buffer; a pending read-result keeps its copy
		if (pop_fire)
		begin
			s_next.buffer = sat_code(fifo_data);
			if (s_reg.st == acsi_pkg::ST_CMD)
			begin
				s_next.out_sr = {s_next.buffer, acsi_pkg::RESULT_TRAILER};
				s_next.out_cnt = 6'h00;
				if (s_reg.cfg[acsi_pkg::REG_CURRENT_ROUTING_READY_CFG][acsi_pkg::READY_SEL_BIT])
					s_next.dout = 1'b0;
			end
		end
		// Output shifts on rising edges; ones fill behind the data
		if (sclk_rise)
		begin
			s_next.dout = s_next.out_sr[31];
			s_next.out_sr = {s_next.out_sr[30:0], 1'b1};
			if (s_next.out_cnt < 6'h20)
				s_next.out_cnt = s_next.out_cnt + 6'h01;
			s_next.rdy_n = 1'b1;
			s_next.unread = 1'b0;
		end
		// A new result outranks a read edge in the same cycle, so none goes unflagged
		if (pop_fire)
		begin
			s_next.unread = 1'b1;
			s_next.rdy_n = 1'b0;
		end
		if (cs_fall)
		begin
			s_next.oe_n = 1'b0;
			if (s_reg.cfg[acsi_pkg::REG_CURRENT_ROUTING_READY_CFG][acsi_pkg::READY_SEL_BIT])
				s_next.dout = !s_next.unread;
			else
				s_next.dout = s_next.out_sr[31];
		end
		// Input sampled on falling edges, decoded on byte boundaries
		if (sclk_fall)
		begin
			s_next.shin = rx_byte;
			s_next.bit_cnt = s_reg.bit_cnt + 3'h1;
		end
		if (byte_done)
		begin
			case (s_reg.st)
				acsi_pkg::ST_CMD:
				begin
					// Commands arriving inside the reset wait are dropped
					if (s_reg.hold_cnt != '0)
						s_next.st = acsi_pkg::ST_CMD;
					else if (rx_byte[7:1] == acsi_pkg::CMD_RESET_PAT)
					begin
						s_next.cfg = '0;
						s_next.dev_reset = 1'b1;
						s_next.hold_cnt = acsi_pkg::RESET_HOLD_CYC;
						s_next.sleeping = 1'b0;
						s_next.pd_pending = 1'b0;
					end
					else if (rx_byte[7:1] == acsi_pkg::CMD_START_PAT)
					begin
						s_next.conv_start = 1'b1;
						s_next.filter_clear = 1'b1;
						s_next.sleeping = 1'b0;
						s_next.pd_pending = 1'b0;
					end
					else if (rx_byte[7:1] == acsi_pkg::CMD_SLEEP_PAT)
						s_next.pd_pending = 1'b1;
					else if (rx_byte[7:4] == acsi_pkg::CMD_RDATA_NIB)
					begin
						s_next.out_sr = {s_reg.buffer, acsi_pkg::RESULT_TRAILER};
						s_next.out_cnt = 6'h00;
						s_next.unread = 1'b0;
						s_next.remain = 2'h1;
						s_next.st = acsi_pkg::ST_RDATA;
					end
					else if (rx_byte[7:4] == acsi_pkg::CMD_REGISTER_READ_CMD_NIB)
					begin
						s_next.out_sr = {s_reg.cfg[rx_byte[3:2]], acsi_pkg::REG_FILL};
						s_next.out_cnt = 6'h20;
						s_next.ptr = rx_byte[3:2];
						s_next.remain = rx_byte[1:0];
						s_next.st = acsi_pkg::ST_REGISTER_READ_CMD;
					end
					else if (rx_byte[7:4] == acsi_pkg::CMD_REGISTER_WRITE_CMD_NIB)
					begin
						s_next.ptr = rx_byte[3:2];
						s_next.remain = rx_byte[1:0];
						s_next.stage = s_reg.cfg;
						s_next.st = acsi_pkg::ST_REGISTER_WRITE_CMD;
					end
					else
						s_next.st = acsi_pkg::ST_CMD;
				end
				acsi_pkg::ST_RDATA:
				begin
					// Din is ignored until both result bytes are out
					if (s_reg.remain == 2'h0)
						s_next.st = acsi_pkg::ST_CMD;
					else
						s_next.remain = s_reg.remain - 2'h1;
				end
				acsi_pkg::ST_REGISTER_READ_CMD:
				begin
					if (s_reg.remain == 2'h0)
						s_next.st = acsi_pkg::ST_CMD;
					else
					begin
						s_next.remain = s_reg.remain - 2'h1;
						s_next.ptr = s_reg.ptr + 2'h1;
						s_next.out_sr = {s_reg.cfg[s_reg.ptr + 2'h1], acsi_pkg::REG_FILL};
					end
				end
				acsi_pkg::ST_REGISTER_WRITE_CMD:
				begin
					s_next.stage[s_reg.ptr] = rx_byte;
					s_next.ptr = s_reg.ptr + 2'h1;
					s_next.remain = s_reg.remain - 2'h1;
					if (s_reg.remain == 2'h0)
					begin
						s_next.cfg = s_next.stage;
						s_next.cfg[acsi_pkg::REG_CURRENT_ROUTING_READY_CFG] =
							s_next.stage[acsi_pkg::REG_CURRENT_ROUTING_READY_CFG]
							& acsi_pkg::ROUTING_WRITE_MASK;
						s_next.filter_clear = 1'b1;
						s_next.conv_start = 1'b1;
						s_next.sleeping = 1'b0;
						s_next.pd_pending = 1'b0;
						s_next.st = acsi_pkg::ST_CMD;
					end
				end
				default:
					s_next.st = acsi_pkg::ST_CMD;
			endcase
		end
		// Timeout only runs while a command or transfer is half done
		if (sclk_rise || sclk_fall || pins_s.cs_n
			|| (s_reg.st == acsi_pkg::ST_CMD && s_reg.bit_cnt == 3'h0))
			s_next.to_cnt = '0;
		else if (s_reg.to_cnt >= to_limit)
		begin
			s_next.to_cnt = '0;
			s_next.st = acsi_pkg::ST_CMD;
			s_next.bit_cnt = 3'h0;
		end
		else
			s_next.to_cnt = s_reg.to_cnt + 1'b1;
		// Deselect resets the serial side and releases the shared line
		if (pins_s.cs_n)
		begin
			s_next.oe_n = 1'b1;
			s_next.st = acsi_pkg::ST_CMD;
			s_next.bit_cnt = 3'h0;
		end
		// Power-down waits for the running conversion to end
		if (s_next.pd_pending && !conv_busy)
		begin
			s_next.sleeping = 1'b1;
			s_next.pd_pending = 1'b0;
		end
		// Switch and excitation follow registers; sleep keeps registers but turns all analog controls off
		s_next.analog_on = !s_next.sleeping;
		s_next.lsw = !s_next.sleeping
			&& s_next.cfg[acsi_pkg::REG_REFERENCE_FILTER_CURRENT][acsi_pkg::LOW_SIDE_SW_BIT];
		s_next.exc = s_next.sleeping ? 3'h0 :
			s_next.cfg[acsi_pkg::REG_REFERENCE_FILTER_CURRENT][acsi_pkg::EXC_LSB +: 3];
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			s_reg <= '0;
			s_reg.cs_d <= 1'b1;
			s_reg.dout <= 1'b1;
			s_reg.oe_n <= 1'b1;
			s_reg.rdy_n <= 1'b1;
			s_reg.analog_on <= 1'b1;
			s_reg.out_cnt <= 6'h20;
			s_reg.out_sr <= '1;
		end
		else
			s_reg <= s_next;
	end

	assign serial_out_with_ready = s_reg.dout;
	assign serial_out_with_ready_oe_n = s_reg.oe_n;
	assign result_ready_n = s_reg.rdy_n;
	assign conv_start = s_reg.conv_start;
	assign filter_clear = s_reg.filter_clear;
	assign device_reset = s_reg.dev_reset;
	assign conversion_mode_sel = s_reg.cfg[acsi_pkg::REG_RATE_MODE_CONVERSION][acsi_pkg::CONV_MODE_BIT];
	assign analog_on = s_reg.analog_on;
	assign low_side_switch_ctl = s_reg.lsw;
	assign excitation_current_src = s_reg.exc;
	assign cfg_out = s_reg.cfg;

	a_clip_high: assert property (@(posedge sys_clk) disable iff (rst)
		pop_fire && ($signed(fifo_data) > $signed(RAW_W'($signed(acsi_pkg::CODE_MAX))))
		|=> s_reg.buffer == 16'h7fff)
		else $error("result not clipped to largest code");
	a_reset_defaults: assert property (@(posedge sys_clk) disable iff (rst)
		byte_done && s_reg.st == acsi_pkg::ST_CMD && s_reg.hold_cnt == '0
		&& rx_byte[7:1] == acsi_pkg::CMD_RESET_PAT
		|=> device_reset && cfg_out == '0 && s_reg.hold_cnt == acsi_pkg::RESET_HOLD_CYC)
		else $error("reset command did not restore defaults");
	a_start_restart: assert property (@(posedge sys_clk) disable iff (rst)
		byte_done && s_reg.st == acsi_pkg::ST_CMD && s_reg.hold_cnt == '0
		&& rx_byte[7:1] == acsi_pkg::CMD_START_PAT
		|=> conv_start && filter_clear ##1 !conv_start)
		else $error("start command pulse wrong");
	a_sleep_waits: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(s_reg.sleeping) |-> !$past(conv_busy) ##1 (!analog_on && excitation_current_src == 3'h0))
		else $error("power-down entered during conversion or analog left on");
	a_ready_falls: assert property (@(posedge sys_clk) disable iff (rst)
		pop_fire |=> !result_ready_n)
		else $error("ready output did not fall on new result");
	a_ready_returns: assert property (@(posedge sys_clk) disable iff (rst)
		sclk_rise && !pop_fire |=> result_ready_n)
		else $error("ready output not high after rising clock");
	a_release_desel: assert property (@(posedge sys_clk) disable iff (rst)
		pins_s.cs_n |=> serial_out_with_ready_oe_n)
		else $error("serial out driven while deselected");
	a_ready_at_sel: assert property (@(posedge sys_clk) disable iff (rst)
		cs_fall && !pop_fire && !sclk_rise
		&& s_reg.cfg[acsi_pkg::REG_CURRENT_ROUTING_READY_CFG][acsi_pkg::READY_SEL_BIT]
		|=> !serial_out_with_ready_oe_n && (serial_out_with_ready == !$past(s_reg.unread)))
		else $error("serial out does not show unread data at select");
	a_read_locked: assert property (@(posedge sys_clk) disable iff (rst)
		byte_done && s_reg.st == acsi_pkg::ST_RDATA && s_reg.remain != 2'h0
		|=> s_reg.st == acsi_pkg::ST_RDATA)
		else $error("read-result ended before sixteen bits");
	a_write_restart: assert property (@(posedge sys_clk) disable iff (rst)
		byte_done && s_reg.st == acsi_pkg::ST_REGISTER_WRITE_CMD && s_reg.remain == 2'h0
		|=> filter_clear && conv_start && s_reg.st == acsi_pkg::ST_CMD)
		else $error("register write did not restart conversion");
endmodule : acsi_top

// *** acsi_host.sv ***
// Host controller model driving the converter's serial pins
`timescale 1ns/1ps
module acsi_host (
	input wire logic sys_clk,
	input wire logic dout,
	input wire logic oe_n,
	output acsi_pkg::acsi_pins_t pins,
	output logic [7:0] rx_byte,
	output logic rx_stb
);
	initial
	begin
		pins = 3'h4;
		rx_byte = 8'h00;
		rx_stb = 1'b0;
	end
	// Chip select change; the serial clock stays parked low outside frames
	task automatic sel(input logic on);
		pins.cs_n <= ~on;
		repeat (4) @(posedge sys_clk);
	endtask : sel
	// One byte MSB first at 800 ns a bit: drive on the rising edge,
	// take the reply just before the falling edge
	// Fewer than eight bits leave a byte cut short, for the timeout
	task automatic xfer(input logic [7:0] tx, input int nb = 8);
		logic [7:0] rx;
		for (int i = 7; i >= 8 - nb; i--)
		begin
			pins.sclk <= 1'b1;
			pins.din <= tx[i];
			repeat (4) @(posedge sys_clk);
			rx[i] = (oe_n === 1'b0) ? dout : 1'bx; // Released line reads unknown
			pins.sclk <= 1'b0;
			repeat (4) @(posedge sys_clk);
		end
		rx_byte <= rx;
		rx_stb <= 1'b1;
		@(posedge sys_clk);
		rx_stb <= 1'b0;
	endtask : xfer
endmodule : acsi_host

// *** tb_top.sv ***
// Self-checking bench of the serial command interface
`timescale 1ns/1ps
module tb_top;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	acsi_pkg::acsi_pins_t pins;
	logic dout, oe_n, rdy_n, raw_valid, raw_ready, conv_busy, rx_stb;
	logic conv_start, filter_clear, device_reset, cmode, analog_on, lsw;
	logic [2:0] exc;
	logic [19:0] raw_data;
	logic [7:0] rx_byte;
	logic [15:0] e;
	acsi_pkg::acsi_cfg_t cfg;
	logic [8:0] exp_q[$];
	logic [7:0] w [4];
	logic [19:0] vals [5];
	integer seed = 32'h882fcfa2;
	int miscompares = 0;
	int checked = 0;
	int cycles = 0;
	int n_start = 0;
	int n_clr = 0;
	int n_rst = 0;
	int n;
	always #50 sys_clk = ~sys_clk;
	acsi_top #(.TIMEOUT_NORMAL_CYC(200), .TIMEOUT_TURBO_CYC(200)) dut_u (
		.sys_clk(sys_clk), .rst(rst), .pins(pins), .serial_out_with_ready(dout),
		.serial_out_with_ready_oe_n(oe_n), .result_ready_n(rdy_n),
		.raw_valid(raw_valid), .raw_data(raw_data), .raw_ready(raw_ready),
		.conv_busy(conv_busy), .conv_start(conv_start), .filter_clear(filter_clear),
		.device_reset(device_reset), .conversion_mode_sel(cmode), .analog_on(analog_on),
		.low_side_switch_ctl(lsw), .excitation_current_src(exc), .cfg_out(cfg));
	acsi_host host_u (.sys_clk(sys_clk), .dout(dout), .oe_n(oe_n), .pins(pins),
		.rx_byte(rx_byte), .rx_stb(rx_stb));
	task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
		checked++;
		if (got !== want)
		begin
			miscompares++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
		end
	endtask : chk
	task automatic give_verdict();
		if (miscompares == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : give_verdict
	// Note the reply first, so the watcher always finds it queued
	task automatic io(input logic [7:0] tx, input logic [8:0] ex);
		exp_q.push_back(ex);
		host_u.xfer(tx);
	endtask : io
	task automatic cmd(input logic [7:0] c);
		host_u.sel(1'b1);
		io(c, 9'h000);
		host_u.sel(1'b0);
	endtask : cmd
	// Push one raw result, held until the FIFO takes it
	task automatic push(input logic [19:0] v);
		raw_valid <= 1'b1;
		raw_data <= v;
		@(posedge sys_clk);
		while (raw_ready !== 1'b1)
			@(posedge sys_clk);
		raw_valid <= 1'b0;
		n = 0;
		while (rdy_n !== 1'b0 && n < 50)
		begin
			@(posedge sys_clk);
			n++;
		end
		chk(rdy_n, 1'b0, "ready falls");
	endtask : push
	function automatic logic [15:0] clip(input logic [19:0] x);
		if ($signed(x) > $signed(20'h07fff))
			return 16'h7fff;
		if ($signed(x) < $signed(20'hf8000))
			return 16'h8000;
		return x[15:0];
	endfunction : clip
	// Bytes with bit 8 clear are don't-care and only consumed
	always @(posedge sys_clk)
	begin
		if (rx_stb === 1'b1 && exp_q.size() > 0)
		begin
			if (exp_q[0][8])
				chk(rx_byte, exp_q[0][7:0], "serial byte");
			void'(exp_q.pop_front());
		end
	end
	// Control pulses last one cycle, so a count shows doubles and misses
	always @(posedge sys_clk)
	begin
		if (conv_start === 1'b1)
			n_start++;
		if (filter_clear === 1'b1)
			n_clr++;
		if (device_reset === 1'b1)
			n_rst++;
	end
	// Hang guard, well above the few thousand cycles the run needs
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			miscompares++;
			give_verdict();
		end
	end
	initial
	begin
		raw_valid = 1'b0;
		raw_data = 20'($random(seed));
		conv_busy = 1'b0;
		vals = '{20'h08000, 20'hf7fff, 20'h7ffff, 20'h80000, 20'h00000};
		vals[4] = 20'($random(seed));
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		chk({oe_n, rdy_n}, 2'h3, "idle pins");
		// Defaults read back as zero
		host_u.sel(1'b1);
		io(8'h23, 9'h000);
		repeat (4) io(8'h00, 9'h100);
		host_u.sel(1'b0);
		// Random write of all four, then a read that wraps past the last register
		foreach (w[i]) w[i] = 8'($random(seed));
		n = n_start + n_clr;
		host_u.sel(1'b1);
		io(8'h43, 9'h000);
		foreach (w[i]) io(w[i], 9'h000);
		host_u.sel(1'b0);
		w[3] = w[3] & acsi_pkg::ROUTING_WRITE_MASK;
		chk(cfg, {w[3], w[2], w[1], w[0]}, "cfg write");
		chk(n_start + n_clr - n, 2, "write restart");
		chk({cmode, lsw, exc}, {w[1][2], w[2][3:0]}, "cfg fields");
		host_u.sel(1'b1);
		io(8'h2b, 9'h000);
		for (int i = 2; i < 6; i++) io(8'h00, {1'b1, w[i % 4]});
		host_u.sel(1'b0);
		// Sleep waits out a busy conversion; start brings the same settings back
		for (int lb = 0; lb < 2; lb++)
		begin
			conv_busy <= 1'b1;
			cmd({7'h01, lb[0]});
			repeat (20) @(posedge sys_clk);
			chk(analog_on, 1'b1, "busy sleep");
			conv_busy <= 1'b0;
			repeat (4) @(posedge sys_clk);
			chk({analog_on, lsw, exc, cfg[2]}, {5'h00, w[2]}, "asleep");
			n = n_start + n_clr;
			cmd({7'h04, lb[0]});
			chk({analog_on, lsw, exc}, {1'b1, w[2][3:0]}, "woken");
			chk(n_start + n_clr - n, 2, "start");
		end
		n = n_start + n_clr + n_rst;
		cmd(8'hff);
		cmd(8'h30);
		chk(n_start + n_clr + n_rst - n, 0, "unknown");
		chk(cfg[1], w[1], "unknown keeps");
		// A cut byte must time out, or the start below would be misaligned
		n = n_start;
		host_u.sel(1'b1);
		host_u.xfer(8'h00, 3);
		repeat (250) @(posedge sys_clk);
		io(8'h08, 9'h000);
		host_u.sel(1'b0);
		chk(n_start - n, 1, "timeout");
		// Ready shown on the data line from here on
		host_u.sel(1'b1);
		io(8'h4c, 9'h000);
		io(8'h02, 9'h000);
		host_u.sel(1'b0);
		for (int i = 0; i < 5; i++)
		begin
			push(vals[i]);
			e = clip(vals[i]);
			host_u.sel(1'b1);
			if (i[0])
				io(8'h10, 9'h000);
			else
				chk({oe_n, dout}, 2'h0, "ready at select");
			io(8'h00, {1'b1, e[15:8]});
			io(8'h00, {1'b1, e[7:0]});
			chk(rdy_n, 1'b1, "ready returns");
			if (!i[0])
				io(8'h00, 9'h100);
			if (!i[0])
				io(8'h00, 9'h1ff);
			host_u.sel(1'b0);
			chk(oe_n, 1'b1, "released");
		end
		host_u.sel(1'b1);
		chk({oe_n, dout}, 2'h1, "nothing new");
		// Stall a direct read mid-result so the FIFO fills until it refuses
		io(8'h00, 9'h1ff);
		host_u.sel(1'b0);
		push(vals[0]);
		host_u.sel(1'b1);
		io(8'h00, 9'h17f);
		raw_valid <= 1'b1;
		raw_data <= vals[4];
		n = 0;
		repeat (40)
		begin
			@(posedge sys_clk);
			if (raw_ready === 1'b1)
				n++;
		end
		raw_valid <= 1'b0;
		chk(n, 16, "fifo fill");
		io(8'h00, 9'h1ff);
		host_u.sel(1'b0);
		host_u.sel(1'b1);
		e = clip(vals[4]);
		io(8'h00, {1'b1, e[15:8]});
		io(8'h00, {1'b1, e[7:0]});
		host_u.sel(1'b0);
		// Reset command clears the registers; the host then keeps quiet
		for (int lb = 0; lb < 2; lb++)
		begin
			n = n_rst;
			cmd({7'h03, lb[0]});
			chk(n_rst - n, 1, "reset pulse");
			chk(cfg, 32'h0, "reset");
			repeat (540) @(posedge sys_clk);
		end
		give_verdict();
	end
endmodule : tb_top
